// ### core/emp_defs.svh
// Constants of the extended memory paging and linear pointer block.
// Assumes an eight-bit CPU data bus and a sixteen-bit CPU address bus.
`ifndef EMP_DEFS_SVH
`define EMP_DEFS_SVH

// Bus and address widths
`define EMP_CPU_AW 16
`define EMP_EXT_AW 17
`define EMP_DW 8
`define EMP_LOW_AW 14
`define EMP_PAGE_BITS 3

// Register addresses in the CPU direct page
`define EMP_ADDR_PAGE 16'h0078
`define EMP_ADDR_PTR_HIGH 16'h0079
`define EMP_ADDR_PTR_MID 16'h007a
`define EMP_ADDR_PTR_LOW 16'h007b
`define EMP_ADDR_WORD_INC 16'h007c
`define EMP_ADDR_BYTE_INC 16'h007d
`define EMP_ADDR_BYTE 16'h007e
`define EMP_ADDR_PTR_ADD 16'h007f

// Paging window: CPU address bits 15:14 equal to this value
`define EMP_WINDOW_TAG 2'h2

// Reset values
`define EMP_PAGE_RESET 8'h02
`define EMP_PTR_RESET 17'h00000

`endif

// ### core/emp_pkg.sv
// Types shared by the extended memory paging and linear pointer block.
// Assumes emp_defs.svh is on the include path.
`include "emp_defs.svh"

package emp_pkg;

  typedef enum logic [3:0] {
    EMP_KIND_MEM = 4'h0,
    EMP_KIND_PAGE = 4'h1,
    EMP_KIND_PTR_HIGH = 4'h2,
    EMP_KIND_PTR_MID = 4'h3,
    EMP_KIND_PTR_LOW = 4'h4,
    EMP_KIND_WORD_INC = 4'h5,
    EMP_KIND_BYTE_INC = 4'h6,
    EMP_KIND_BYTE = 4'h7,
    EMP_KIND_PTR_ADD = 4'h8
  } emp_kind_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`EMP_CPU_AW-1:0] addr;
    logic [`EMP_DW-1:0] wdata;
  } emp_cpu_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`EMP_EXT_AW-1:0] addr;
    logic [`EMP_DW-1:0] wdata;
  } emp_mem_req_t;

endpackage

// ### core/emp_xlate.sv
// Address decode and translation for the paging and linear pointer block.
// Purely combinational; the caller registers whatever it drives out.
`timescale 1ns/1ps
`default_nettype none
`include "emp_defs.svh"

module emp_xlate
  import emp_pkg::*;
(
  // CPU side
  input wire logic [`EMP_CPU_AW-1:0] i_addr,
  // Block state
  input wire logic [`EMP_DW-1:0] i_page,
  input wire logic [`EMP_EXT_AW-1:0] i_pointer,
  // Results
  output emp_kind_t o_kind,
  output logic [`EMP_EXT_AW-1:0] o_ext_addr
);

  logic in_window;
  logic is_linear;
  logic [`EMP_EXT_AW-1:0] window_addr;
  logic [`EMP_EXT_AW-1:0] plain_addr;

  assign in_window = (i_addr[`EMP_CPU_AW-1:`EMP_LOW_AW] == `EMP_WINDOW_TAG);
  // Only eight pages exist, so upper page bits do not reach the address
  assign window_addr = {i_page[`EMP_PAGE_BITS-1:0], i_addr[`EMP_LOW_AW-1:0]};
  assign plain_addr = {1'b0, i_addr};

  assign o_kind = (i_addr == `EMP_ADDR_PAGE) ? EMP_KIND_PAGE :
                  (i_addr == `EMP_ADDR_PTR_HIGH) ? EMP_KIND_PTR_HIGH :
                  (i_addr == `EMP_ADDR_PTR_MID) ? EMP_KIND_PTR_MID :
                  (i_addr == `EMP_ADDR_PTR_LOW) ? EMP_KIND_PTR_LOW :
                  (i_addr == `EMP_ADDR_WORD_INC) ? EMP_KIND_WORD_INC :
                  (i_addr == `EMP_ADDR_BYTE_INC) ? EMP_KIND_BYTE_INC :
                  (i_addr == `EMP_ADDR_BYTE) ? EMP_KIND_BYTE :
                  (i_addr == `EMP_ADDR_PTR_ADD) ? EMP_KIND_PTR_ADD :
                  EMP_KIND_MEM;

  assign is_linear = (o_kind == EMP_KIND_WORD_INC) || (o_kind == EMP_KIND_BYTE_INC) ||
                     (o_kind == EMP_KIND_BYTE);

  // Linear ports use the pointer whatever page runs code
  assign o_ext_addr = is_linear ? i_pointer :
                      in_window ? window_addr : plain_addr;

endmodule
`default_nettype wire

// ### core/emp_mmu.sv
// Extended memory paging and linear pointer logic, top level.
// Sits between a byte-wide CPU bus and a 128K extended memory; the memory
// answers a read in the same cycle that its request stands on o_mem_req.
`timescale 1ns/1ps
`default_nettype none
`include "emp_defs.svh"

// How it works
// - pointer is 17 bits; data ports address it
// - auto-increment ports step pointer; plain port holds
// - word port read returns data, then increments
// - word port write stores data, then increments
// - byte auto-increment port follows word port
// - add port adds signed byte to pointer
// - paging window goes to selected flash block
// - window address is page bits 2:0 over CPU bits 13:0
// - reset loads page select with two
// - page select readable, writable, stacked by calls
// - linear ports reach any page
// - extended space totals 128K bytes
// - far call pushes page, loads new, uninterrupted
// - byte auto-increment port mirrors word port
module emp_mmu
  import emp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // CPU byte access, one per cycle at most
  input wire emp_cpu_req_t i_cpu_req,
  output emp_cpu_req_t o_unused_placeholder_never,
  output logic [`EMP_DW-1:0] o_cpu_rdata,
  output logic o_cpu_rvalid,
  // Far call and far return page control
  input wire logic i_page_load,
  input wire logic [`EMP_DW-1:0] i_page_value,
  output logic [`EMP_DW-1:0] o_program_page_select,
  // Extended memory side
  output emp_mem_req_t o_mem_req,
  input wire logic [`EMP_DW-1:0] i_mem_rdata,
  // Pointer state for observation
  output logic [`EMP_EXT_AW-1:0] o_linear_pointer
);

  emp_kind_t kind;
  logic [`EMP_EXT_AW-1:0] ext_addr;
  logic [`EMP_DW-1:0] page;
  logic [`EMP_EXT_AW-1:0] pointer;
  logic [`EMP_DW-1:0] wdata;
  logic req_valid;
  logic req_write;
  logic req_read;
  logic is_step;
  logic is_linear;
  logic is_reg;
  logic [`EMP_EXT_AW-1:0] ptr_inc;
  logic [`EMP_EXT_AW-1:0] ptr_sum;
  logic [`EMP_EXT_AW-1:0] next_pointer;
  logic [`EMP_DW-1:0] next_page;
  logic [`EMP_DW-1:0] reg_rdata;
  emp_mem_req_t next_mem_req;
  logic s1_read;
  logic s1_reg;
  logic [`EMP_DW-1:0] s1_reg_data;

  emp_xlate u_xlate (
    .i_addr(i_cpu_req.addr),
    .i_page(page),
    .i_pointer(pointer),
    .o_kind(kind),
    .o_ext_addr(ext_addr)
  );

  assign req_valid = i_cpu_req.valid;
  assign req_write = req_valid && i_cpu_req.write;
  assign req_read = req_valid && !i_cpu_req.write;
  assign wdata = i_cpu_req.wdata;

  // Both auto-increment ports act the same; only their addresses differ
  assign is_step = req_valid && ((kind == EMP_KIND_WORD_INC) ||
                                 (kind == EMP_KIND_BYTE_INC));
  assign is_linear = is_step || (req_valid && (kind == EMP_KIND_BYTE));
  assign is_reg = req_valid && (kind != EMP_KIND_MEM) && !is_linear;

  // Arithmetic keeps 17 bits so the pointer wraps inside the space
  assign ptr_inc = pointer + `EMP_EXT_AW'(1);
  assign ptr_sum = pointer + {{(`EMP_EXT_AW-`EMP_DW){wdata[`EMP_DW-1]}}, wdata};

  always_comb begin
    next_pointer = pointer;
    if (is_step) begin
      next_pointer = ptr_inc;
    end else if (req_write) begin
      case (kind)
        EMP_KIND_PTR_HIGH: next_pointer = {wdata[0], pointer[15:0]};
        EMP_KIND_PTR_MID: next_pointer = {pointer[16], wdata, pointer[7:0]};
        EMP_KIND_PTR_LOW: next_pointer = {pointer[16:8], wdata};
        EMP_KIND_PTR_ADD: next_pointer = ptr_sum;
        default: next_pointer = pointer;
      endcase
    end
  end

  // A far call or return outranks a plain write landing in the same cycle
  assign next_page = i_page_load ? i_page_value :
                     (req_write && (kind == EMP_KIND_PAGE)) ? wdata : page;

  // Reads of the add port return zero; it holds no value of its own
  assign reg_rdata = (kind == EMP_KIND_PAGE) ? page :
                     (kind == EMP_KIND_PTR_HIGH) ? {7'h00, pointer[16]} :
                     (kind == EMP_KIND_PTR_MID) ? pointer[15:8] :
                     (kind == EMP_KIND_PTR_LOW) ? pointer[7:0] : 8'h00;

  // Memory address is taken from the pointer before it steps
  assign next_mem_req.valid = req_valid && !is_reg;
  assign next_mem_req.write = req_write;
  assign next_mem_req.addr = ext_addr;
  assign next_mem_req.wdata = wdata;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      page <= `EMP_PAGE_RESET;
      pointer <= `EMP_PTR_RESET;
    end else begin
      page <= next_page;
      pointer <= next_pointer;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_mem_req <= '0;
      s1_read <= 1'b0;
      s1_reg <= 1'b0;
      s1_reg_data <= 8'h00;
    end else begin
      o_mem_req <= next_mem_req;
      s1_read <= req_read;
      s1_reg <= is_reg;
      s1_reg_data <= reg_rdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_cpu_rdata <= 8'h00;
      o_cpu_rvalid <= 1'b0;
    end else begin
      o_cpu_rdata <= s1_reg ? s1_reg_data : i_mem_rdata;
      o_cpu_rvalid <= s1_read;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_program_page_select <= `EMP_PAGE_RESET;
      o_linear_pointer <= `EMP_PTR_RESET;
      o_unused_placeholder_never <= '0;
    end else begin
      o_program_page_select <= next_page;
      o_linear_pointer <= next_pointer;
      o_unused_placeholder_never <= '0;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // Helper copies for checks only
  logic [`EMP_EXT_AW-1:0] chk_add_ext;
  logic chk_word;
  logic chk_byte_inc;
  logic chk_window;
  assign chk_add_ext = {{(`EMP_EXT_AW-`EMP_DW){wdata[`EMP_DW-1]}}, wdata};
  assign chk_word = req_valid && (i_cpu_req.addr == `EMP_ADDR_WORD_INC);
  assign chk_byte_inc = req_valid && (i_cpu_req.addr == `EMP_ADDR_BYTE_INC);
  assign chk_window = req_valid &&
                      (i_cpu_req.addr[`EMP_CPU_AW-1:`EMP_LOW_AW] == `EMP_WINDOW_TAG);

  sequence s_word_read;
    chk_word && !i_cpu_req.write;
  endsequence

  sequence s_mem_read_issued;
    o_mem_req.valid && !o_mem_req.write;
  endsequence

  sequence s_word_pair;
    chk_word ##1 chk_byte_inc;
  endsequence

  a_page_reset: assert property ($fell(i_srst) |-> page == `EMP_PAGE_RESET)
    else $error("page select not two after reset");

  a_step_inc: assert property ((chk_word || chk_byte_inc) |=>
      pointer == `EMP_EXT_AW'($past(pointer) + 1))
    else $error("auto-increment port did not step pointer by one");

  a_plain_hold: assert property ((req_valid && i_cpu_req.addr == `EMP_ADDR_BYTE) |=>
      $stable(pointer))
    else $error("plain data port moved the pointer");

  a_word_read: assert property (s_word_read |=>
      (s_mem_read_issued and (o_mem_req.addr == $past(pointer))) ##1 o_cpu_rvalid)
    else $error("word port read not served from old pointer");

  a_word_write: assert property ((chk_word && i_cpu_req.write) |=>
      o_mem_req.valid && o_mem_req.write && o_mem_req.addr == $past(pointer) &&
      o_mem_req.wdata == $past(wdata))
    else $error("word port write not stored at old pointer");

  a_word_pair: assert property (s_word_pair |=>
      pointer == `EMP_EXT_AW'($past(pointer, 2) + 2))
    else $error("two-byte access did not step pointer twice");

  a_ptr_add: assert property ((req_write && i_cpu_req.addr == `EMP_ADDR_PTR_ADD) |=>
      pointer == `EMP_EXT_AW'($past(pointer) + $past(chk_add_ext)))
    else $error("signed add gave wrong pointer");

  a_window_map: assert property ((chk_window && !is_reg) |=>
      o_mem_req.valid &&
      o_mem_req.addr == {$past(page[`EMP_PAGE_BITS-1:0]),
                         $past(i_cpu_req.addr[`EMP_LOW_AW-1:0])})
    else $error("window access not mapped through page select");

  a_page_load: assert property (i_page_load |=>
      o_program_page_select == $past(i_page_value) && page == $past(i_page_value))
    else $error("far call or return did not load page select");

  a_page_read: assert property ((req_read && i_cpu_req.addr == `EMP_ADDR_PAGE) |=>
      !o_mem_req.valid ##1 (o_cpu_rvalid && o_cpu_rdata == $past(page, 2)))
    else $error("page select read returned wrong value");

  a_linear_any: assert property ((chk_byte_inc && !i_cpu_req.write) |=>
      o_mem_req.addr == $past(pointer))
    else $error("byte auto-increment read not at pointer");

  a_wrap: assert property ((chk_word || chk_byte_inc) && pointer == '1 |=> pointer == '0)
    else $error("pointer failed to wrap at top of space");

  a_ptr_high: assert property ((req_write && i_cpu_req.addr == `EMP_ADDR_PTR_HIGH) |=>
      pointer == {$past(wdata[0]), $past(pointer[15:0])})
    else $error("high pointer write landed wrongly");

  a_ptr_mid: assert property ((req_write && i_cpu_req.addr == `EMP_ADDR_PTR_MID) |=>
      pointer == {$past(pointer[16]), $past(wdata), $past(pointer[7:0])})
    else $error("middle pointer write landed wrongly");

  a_ptr_low: assert property ((req_write && i_cpu_req.addr == `EMP_ADDR_PTR_LOW) |=>
      pointer == {$past(pointer[16:8]), $past(wdata)})
    else $error("low pointer write landed wrongly");

  a_reg_no_mem: assert property (is_reg |=> !o_mem_req.valid)
    else $error("register access reached memory");

  a_read_answer: assert property (req_read |-> ##2 o_cpu_rvalid)
    else $error("read not answered two cycles later");

  a_write_silent: assert property (req_write |-> ##2 !o_cpu_rvalid)
    else $error("write produced a read answer");

  a_plain_read: assert property ((req_read && i_cpu_req.addr == `EMP_ADDR_BYTE) |=>
      o_mem_req.valid && o_mem_req.addr == $past(pointer))
    else $error("plain port read not at pointer");

  a_byte_write: assert property ((chk_byte_inc && i_cpu_req.write) |=>
      o_mem_req.valid && o_mem_req.write && o_mem_req.addr == $past(pointer) &&
      o_mem_req.wdata == $past(wdata))
    else $error("byte auto-increment write not stored at pointer");

  a_load_wins: assert property ((i_page_load && req_write && kind == EMP_KIND_PAGE) |=>
      page == $past(i_page_value))
    else $error("plain page write beat a far call load");

  a_page_write: assert property ((req_write && kind == EMP_KIND_PAGE && !i_page_load) |=>
      page == $past(wdata))
    else $error("page select write not taken");

  a_out_mirror: assert property (o_program_page_select == page && o_linear_pointer == pointer)
    else $error("observed outputs differ from held state");

  a_high_read: assert property ((req_read && i_cpu_req.addr == `EMP_ADDR_PTR_HIGH) |->
      ##2 o_cpu_rdata == {7'h00, $past(pointer[16], 2)})
    else $error("high pointer read returned wrong value");

  a_plain_map: assert property ((req_valid && kind == EMP_KIND_MEM && !chk_window) |=>
      o_mem_req.valid && o_mem_req.addr == {1'b0, $past(i_cpu_req.addr)})
    else $error("address outside window not passed through");

endmodule
`default_nettype wire

// ### verif/emp_mem_model.sv
// Behavioural byte-wide extended memory facing the paging block.
// Answers a read in the same cycle that the request stands; starts as a fixed pattern.
`timescale 1ns/1ps
`default_nettype none

module emp_mem_model
  import emp_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Memory request and read data
  input wire emp_mem_req_t i_mem_req,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:131071];
  logic [7:0] last = 8'h00;
  wire rd_now = i_mem_req.valid && !i_mem_req.write;

  // Idle cycles show the inverse of the last byte, so stale data cannot pass
  assign o_rdata = rd_now ? mem[i_mem_req.addr] : ~last;

  initial begin
    for (int i = 0; i < 131072; i++) begin
      mem[i] = i[7:0] ^ {5'h00, i[16:14]};
    end
  end

  always @(posedge i_core_clk) begin
    last <= o_rdata;
    if (i_mem_req.valid && i_mem_req.write) begin
      mem[i_mem_req.addr] <= i_mem_req.wdata;
    end
  end
endmodule

`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the paging and linear pointer block.
// Assumes emp_pkg, emp_mmu and emp_mem_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "emp_defs.svh"

module tb
  import emp_pkg::*;
;
  logic core_clk, srst, page_load, cpu_rvalid;
  logic [7:0] page_value, mem_rdata, cpu_rdata, page_sel;
  logic [16:0] ptr;
  emp_cpu_req_t cpu_req;
  emp_mem_req_t mem_req;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2.5 core_clk = ~core_clk;

  emp_mmu dut (.i_core_clk(core_clk), .i_srst(srst), .i_cpu_req(cpu_req),
    .o_unused_placeholder_never(), .o_cpu_rdata(cpu_rdata), .o_cpu_rvalid(cpu_rvalid),
    .i_page_load(page_load), .i_page_value(page_value), .o_program_page_select(page_sel),
    .o_mem_req(mem_req), .i_mem_rdata(mem_rdata), .o_linear_pointer(ptr));
  emp_mem_model u_mem (.i_core_clk(core_clk), .i_mem_req(mem_req), .o_rdata(mem_rdata));

  task automatic summarize;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    // Whole run needs under 200 cycles
    if (cycles == 2000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk17(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t address got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] pat(input logic [16:0] a);
    return a[7:0] ^ {5'h00, a[16:14]};
  endfunction

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  task automatic drive(input logic w, input logic [15:0] a, input logic [7:0] d);
    cpu_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
    step();
    cpu_req.valid = 1'b0;
  endtask

  // Memory request checked in the cycle after the taking edge, data one cycle later
  task automatic rd(input logic [15:0] a, input logic m, input logic [16:0] ma,
                    input logic [7:0] d);
    drive(1'b0, a, 8'h00);
    chk8({7'h00, mem_req.valid}, {7'h00, m});
    if (m) begin
      chk17(mem_req.addr, ma);
    end
    step();
    chk8({7'h00, cpu_rvalid}, 8'h01);
    chk8(cpu_rdata, d);
  endtask

  task automatic do_reset(input int n);
    srst = 1'b1;
    repeat (n) step();
    srst = 1'b0;
    chk8(page_sel, 8'h02);
    chk17(ptr, 17'h00000);
    chk8({7'h00, mem_req.valid, cpu_rvalid}, 8'h00);
  endtask

  task automatic t_linear;
    drive(1'b1, `EMP_ADDR_PTR_HIGH, 8'h01);
    drive(1'b1, `EMP_ADDR_PTR_MID, 8'hff);
    drive(1'b1, `EMP_ADDR_PTR_LOW, 8'hfe);
    chk17(ptr, 17'h1fffe);
    rd(`EMP_ADDR_PTR_LOW, 1'b0, 17'h00000, 8'hfe);
    rd(`EMP_ADDR_PTR_HIGH, 1'b0, 17'h00000, 8'h01);
    rd(`EMP_ADDR_BYTE, 1'b1, 17'h1fffe, pat(17'h1fffe));
    chk17(ptr, 17'h1fffe);
    rd(`EMP_ADDR_WORD_INC, 1'b1, 17'h1fffe, pat(17'h1fffe));
    chk17(ptr, 17'h1ffff);
    rd(`EMP_ADDR_BYTE_INC, 1'b1, 17'h1ffff, pat(17'h1ffff));
    chk17(ptr, 17'h00000);
  endtask

  task automatic t_word_write;
    drive(1'b1, `EMP_ADDR_PTR_LOW, 8'h40);
    cpu_req = '{1'b1, 1'b1, `EMP_ADDR_WORD_INC, 8'h5a};
    step();
    chk17(mem_req.addr, 17'h00040);
    chk8(mem_req.wdata, 8'h5a);
    chk8({6'h00, mem_req.valid, mem_req.write}, 8'h03);
    cpu_req = '{1'b1, 1'b1, `EMP_ADDR_BYTE_INC, 8'ha5};
    step();
    cpu_req.valid = 1'b0;
    chk17(mem_req.addr, 17'h00041);
    chk8(mem_req.wdata, 8'ha5);
    step();
    chk17(ptr, 17'h00042);
    drive(1'b1, `EMP_ADDR_PTR_LOW, 8'h40);
    rd(`EMP_ADDR_BYTE, 1'b1, 17'h00040, 8'h5a);
  endtask

  task automatic t_add;
    logic [7:0] v [3] = '{8'h7f, 8'h80, 8'hff};
    logic [16:0] e [3] = '{17'h0007f, 17'h1ffff, 17'h1fffe};
    drive(1'b1, `EMP_ADDR_PTR_LOW, 8'h00);
    for (int i = 0; i < 3; i++) begin
      drive(1'b1, `EMP_ADDR_PTR_ADD, v[i]);
      chk17(ptr, e[i]);
    end
    rd(`EMP_ADDR_PTR_ADD, 1'b0, 17'h00000, 8'h00);
  endtask

  task automatic t_page;
    drive(1'b1, `EMP_ADDR_PAGE, 8'h05);
    rd(`EMP_ADDR_PAGE, 1'b0, 17'h00000, 8'h05);
    rd(16'h9234, 1'b1, 17'h15234, pat(17'h15234));
    // A far call load wins over a plain page write in the same cycle
    page_load = 1'b1;
    page_value = 8'h03;
    drive(1'b1, `EMP_ADDR_PAGE, 8'h06);
    page_load = 1'b0;
    chk8(page_sel, 8'h03);
    rd(16'ha001, 1'b1, 17'h0e001, pat(17'h0e001));
    rd(16'h4000, 1'b1, 17'h04000, pat(17'h04000));
    do_reset(1);
  endtask

  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    page_load = 1'b0;
    page_value = 8'h00;
    cpu_req = '0;
    do_reset(5);
    t_linear();
    t_word_write();
    t_add();
    t_page();
    summarize();
  end
endmodule

`default_nettype wire
